// File: hdl/driver_config_words.sv
// configuration words zero to three of a registering clock driver, with output control
//
// Contract
// - global inversion bit 1 turns inversion off; a and b sides drive equal levels.
// - inversion on: a follows inputs, listed b address and bank bits inverted.
// - inversion never changes how configuration writes are captured.
// - float bit 1 puts idle command/address outputs of both sides in high impedance.
// - float is independent of inversion and of configuration writes.
// - a disabled side keeps all its outputs, clocks included, in high impedance.
// - a-disable bit 1 disables a-side registered outputs and clock pairs one, three.
// - b-disable bit 1 disables b-side outputs and clock pairs zero, two.
// - clock word bit n at 1 disables clock pair n, 0 enables it.
// - clock loop stays locked while clock pairs are disabled.
// - prelaunch bit 0 gives half clock launch, 1 gives three quarter; control unaffected.
// - timing bit selects 1t at 0, 3t at 1; 3t forbids floating.
// - termination bit selects 100 ohm at 0, 150 ohm at 1; resets to 100.
// - termination applies only to command, control and parity inputs.
// - mirror high turns termination off except on select and odt inputs; here only command/address termination goes off, cke keeps it with control.
// - band bit selects normal band 1 at 0, test band 2 at 1.
// - prelaunch setting holds unchanged at every frequency.
// - drive strength is set per group: command/address, control, clocks; here only command/address strength is set, per side.
// - drive word low pair sets a side, high pair b side; 11 reserved.
// - reset clears the words to zero; clock stop keeps them.
`timescale 1ns/100ps
`include "rcd_map.svh"

module driver_config_words (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] chip_select_inputs,
    input wire logic termination_control_inputs,
    input wire logic clock_enable_inputs,
    input wire logic [15:0] addr_in,
    input wire logic [2:0] bank_in,
    input wire logic ras_in_n,
    input wire logic cas_in_n,
    input wire logic we_in_n,
    input wire logic mirror,
    output rcd_pkg::ca_t ca_out_a,
    output rcd_pkg::ca_t ca_out_b,
    output logic ca_oe_n_a,
    output logic ca_oe_n_b,
    output rcd_pkg::ctl_t ctl_out_a,
    output rcd_pkg::ctl_t ctl_out_b,
    output logic ctl_oe_n_a,
    output logic ctl_oe_n_b,
    output logic [3:0] clock_pair_oe_n,
    output logic clock_loop_locked,
    output logic prelaunch_early,
    output logic timing_3t,
    output logic freq_band_test,
    output logic ibt_150,
    output logic ibt_cmd_on,
    output logic ibt_ctl_on,
    output rcd_pkg::drive_t ca_drive_a,
    output rcd_pkg::drive_t ca_drive_b
);

    logic [3:0] global_features_word;
    logic [3:0] clock_pair_enable_word;
    logic [3:0] timing_and_termination_word;
    logic [3:0] cmd_addr_drive_strength_word;

    // decode: both selects low is a configuration access, never a command
    wire logic cfg_access;
    wire logic [3:0] word_addr;
    wire logic [3:0] word_data;
    wire logic cmd_valid;
    assign cfg_access = chip_select_inputs == 2'b00;
    assign word_addr = {bank_in[2], addr_in[2:0]};
    assign word_data = {bank_in[1], bank_in[0], addr_in[4], addr_in[3]};
    assign cmd_valid = (chip_select_inputs != 2'b11) && !cfg_access;

    // decode uses only select, address and data lines, no stored setting
    wire logic wr_global;
    wire logic wr_clock;
    wire logic wr_timing;
    wire logic wr_drive;
    assign wr_global = cfg_access && word_addr == `WORD_GLOBAL;
    assign wr_clock = cfg_access && word_addr == `WORD_CLOCK;
    assign wr_timing = cfg_access && word_addr == `WORD_TIMING;
    assign wr_drive = cfg_access && word_addr == `WORD_DRIVE;

    wire logic inv_on;
    wire logic float_on;
    wire logic a_dis;
    wire logic b_dis;
    assign inv_on = !global_features_word[`GF_INV_OFF];
    // 3t timing overrides the float request
    assign float_on = global_features_word[`GF_FLOAT] && !timing_and_termination_word[`TM_3T];
    assign a_dis = global_features_word[`GF_A_DIS];
    assign b_dis = global_features_word[`GF_B_DIS];

    function automatic logic keep_drive(input logic [1:0] code);
        keep_drive = code == rcd_pkg::DRIVE_RESERVED;
    endfunction : keep_drive

    wire rcd_pkg::ca_t ca_in;
    wire rcd_pkg::ca_t inv_mask;
    wire rcd_pkg::ca_t next_ca_a;
    wire rcd_pkg::ca_t next_ca_b;
    assign ca_in = '{bank: bank_in, addr: addr_in, ras_n: ras_in_n, cas_n: cas_in_n,
                     we_n: we_in_n};
    assign inv_mask = '{bank: `INV_BANK_MASK, addr: `INV_ADDR_MASK, ras_n: 1'b0,
                        cas_n: 1'b0, we_n: 1'b0};
    // hold the last command between commands so idle lines do not toggle
    assign next_ca_a = cmd_valid ? ca_in : ca_out_a;
    assign next_ca_b = cmd_valid ? (inv_on ? (ca_in ^ inv_mask) : ca_in) : ca_out_b;

    wire logic idle_float;
    wire logic next_ca_oe_n_a;
    wire logic next_ca_oe_n_b;
    assign idle_float = float_on && !cmd_valid;
    assign next_ca_oe_n_a = a_dis || idle_float;
    assign next_ca_oe_n_b = b_dis || idle_float;

    wire rcd_pkg::ctl_t next_ctl;
    assign next_ctl = '{cs_n: cfg_access ? 2'b11 : chip_select_inputs,
                        cke: clock_enable_inputs, odt: termination_control_inputs};

    // pairs one and three belong to side a, zero and two to side b
    wire logic [3:0] side_clk_dis;
    wire logic [3:0] next_clock_oe_n;
    assign side_clk_dis = {a_dis, b_dis, a_dis, b_dis};
    assign next_clock_oe_n = clock_pair_enable_word | side_clk_dis;

    wire logic [1:0] code_a;
    wire logic [1:0] code_b;
    assign code_a = cmd_addr_drive_strength_word[`DS_A_LSB +: 2];
    assign code_b = cmd_addr_drive_strength_word[`DS_B_LSB +: 2];

    // words: cleared by reset only; a stopped clock simply holds them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            global_features_word <= `WORD_RESET;
            clock_pair_enable_word <= `WORD_RESET;
            timing_and_termination_word <= `WORD_RESET;
            cmd_addr_drive_strength_word <= `WORD_RESET;
        end else begin
            if (wr_global) global_features_word <= word_data;
            if (wr_clock) clock_pair_enable_word <= word_data;
            if (wr_timing) timing_and_termination_word <= word_data;
            if (wr_drive) cmd_addr_drive_strength_word <= word_data;
        end
    end

    // registered outputs; all see the stored words, so a write acts from the next cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ca_out_a <= '0;
            ca_out_b <= '0;
            ca_oe_n_a <= 1'b0;
            ca_oe_n_b <= 1'b0;
            ctl_out_a <= '{cs_n: 2'b11, cke: 1'b0, odt: 1'b0};
            ctl_out_b <= '{cs_n: 2'b11, cke: 1'b0, odt: 1'b0};
            ctl_oe_n_a <= 1'b0;
            ctl_oe_n_b <= 1'b0;
            clock_pair_oe_n <= 4'h0;
        end else begin
            ca_out_a <= next_ca_a;
            ca_out_b <= next_ca_b;
            ca_oe_n_a <= next_ca_oe_n_a;
            ca_oe_n_b <= next_ca_oe_n_b;
            ctl_out_a <= next_ctl;
            ctl_out_b <= next_ctl;
            ctl_oe_n_a <= a_dis;
            ctl_oe_n_b <= b_dis;
            clock_pair_oe_n <= next_clock_oe_n;
        end
    end

    // timing, termination and drive settings as seen by the analog side
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clock_loop_locked <= 1'b0;
            prelaunch_early <= 1'b0;
            timing_3t <= 1'b0;
            freq_band_test <= 1'b0;
            ibt_150 <= 1'b0;
            ibt_cmd_on <= 1'b1;
            ibt_ctl_on <= 1'b1;
            ca_drive_a <= rcd_pkg::DRIVE_LIGHT;
            ca_drive_b <= rcd_pkg::DRIVE_LIGHT;
        end else begin
            // lock depends on the input clock alone, never on the clock word
            clock_loop_locked <= 1'b1;
            // one launch bit for all bands; control outputs keep their timing
            prelaunch_early <= timing_and_termination_word[`TM_PRELAUNCH];
            timing_3t <= timing_and_termination_word[`TM_3T];
            freq_band_test <= timing_and_termination_word[`TM_BAND];
            ibt_150 <= timing_and_termination_word[`TM_IBT_150];
            ibt_cmd_on <= !mirror;
            ibt_ctl_on <= 1'b1;
            if (!keep_drive(code_a)) ca_drive_a <= rcd_pkg::drive_t'(code_a);
            if (!keep_drive(code_b)) ca_drive_b <= rcd_pkg::drive_t'(code_b);
        end
    end

    // b side matches a side unless inversion is on
    property b_follows_a;
        @(posedge ref_clk) disable iff (rst)
        ##1 ($past(cmd_valid) && $past(!inv_on)) |-> ca_out_b == ca_out_a;
    endproperty
    inv_off_equal_a: assert property (b_follows_a)
        else $error("b side differs from a side with inversion off");

    inv_on_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 ($past(cmd_valid) && $past(inv_on)) |-> (ca_out_b ^ ca_out_a) == inv_mask)
        else $error("b side not the masked complement of a side");

    write_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 $past(wr_global) |-> global_features_word == $past(word_data))
        else $error("global features write not captured");

    float_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        (float_on && !cmd_valid && !a_dis) ##1 1'b1 |-> ca_oe_n_a)
        else $error("idle outputs not floated");

    no_float_3t_a: assert property (@(posedge ref_clk) disable iff (rst)
        (timing_and_termination_word[`TM_3T] && !a_dis) |=> !ca_oe_n_a)
        else $error("outputs floated in 3t timing");

    side_a_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        a_dis |=> (ca_oe_n_a && ctl_oe_n_a && clock_pair_oe_n[1] && clock_pair_oe_n[3]))
        else $error("a side not disabled");

    side_b_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        b_dis |=> (ca_oe_n_b && ctl_oe_n_b && clock_pair_oe_n[0] && clock_pair_oe_n[2]))
        else $error("b side not disabled");

    clock_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!a_dis && !b_dis) |=> clock_pair_oe_n == $past(clock_pair_enable_word))
        else $error("clock pair enable mismatch");

    mirror_ibt_a: assert property (@(posedge ref_clk) disable iff (rst)
        mirror |=> (!ibt_cmd_on && ibt_ctl_on))
        else $error("mirror termination wrong");

    drive_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        keep_drive(code_a) |=> $stable(ca_drive_a))
        else $error("reserved drive code changed strength");

    drive_hold_b_a: assert property (@(posedge ref_clk) disable iff (rst)
        keep_drive(code_b) |=> $stable(ca_drive_b))
        else $error("reserved drive code changed b strength");

    drive_load_a: assert property (@(posedge ref_clk) disable iff (rst)
        !keep_drive(code_a) |=> ca_drive_a == $past(code_a))
        else $error("a side drive strength not loaded");

    float_idle_b_a: assert property (@(posedge ref_clk) disable iff (rst)
        (float_on && !cmd_valid) |=> ca_oe_n_b)
        else $error("idle b outputs not floated");

    no_float_3t_b_a: assert property (@(posedge ref_clk) disable iff (rst)
        (timing_and_termination_word[`TM_3T] && !b_dis) |=> !ca_oe_n_b)
        else $error("b outputs floated in 3t timing");

    // a real command must never be lost to the float feature
    cmd_drives_a: assert property (@(posedge ref_clk) disable iff (rst)
        (cmd_valid && !a_dis) |=> !ca_oe_n_a)
        else $error("command not driven on a side");

    ctl_a_drives_a: assert property (@(posedge ref_clk) disable iff (rst)
        !a_dis |=> !ctl_oe_n_a)
        else $error("a control outputs floated while enabled");

    ctl_b_drives_a: assert property (@(posedge ref_clk) disable iff (rst)
        !b_dis |=> !ctl_oe_n_b)
        else $error("b control outputs floated while enabled");

    cmd_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
        cmd_valid |=> ca_out_a == $past(ca_in))
        else $error("a side does not follow command inputs");

    locked_stays_a: assert property (@(posedge ref_clk) disable iff (rst)
        (clock_pair_enable_word != 4'h0) |=> clock_loop_locked)
        else $error("clock loop unlocked by clock pair disable");

    prelaunch_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> prelaunch_early == $past(timing_and_termination_word[`TM_PRELAUNCH]))
        else $error("prelaunch setting not applied");

    band_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> freq_band_test == $past(timing_and_termination_word[`TM_BAND]))
        else $error("frequency band setting not applied");

    ibt_value_a: assert property (@(posedge ref_clk) disable iff (rst)
        1'b1 |=> ibt_150 == $past(timing_and_termination_word[`TM_IBT_150]))
        else $error("termination value not applied");

    ibt_select_a: assert property (@(posedge ref_clk) disable iff (rst)
        !mirror |=> (ibt_cmd_on && ibt_ctl_on))
        else $error("termination missing without mirror");

    cover_write_global: cover property (@(posedge ref_clk) disable iff (rst) wr_global);
    cover_inverted_cmd: cover property (@(posedge ref_clk) disable iff (rst)
        cmd_valid && inv_on);
    cover_float_idle: cover property (@(posedge ref_clk) disable iff (rst) idle_float);
    cover_both_off: cover property (@(posedge ref_clk) disable iff (rst) a_dis && b_dis);
    cover_reserved: cover property (@(posedge ref_clk) disable iff (rst) keep_drive(code_a));

endmodule : driver_config_words

// File: hdl/rcd_map.svh
// offsets, bit positions and reset values of the driver configuration words
`ifndef RCD_MAP_SVH
`define RCD_MAP_SVH

// word address formed from {bank[2], addr[2:0]}
`define WORD_GLOBAL 4'h0
`define WORD_CLOCK 4'h1
`define WORD_TIMING 4'h2
`define WORD_DRIVE 4'h3

// global features word bits
`define GF_INV_OFF 0
`define GF_FLOAT 1
`define GF_A_DIS 2
`define GF_B_DIS 3

// timing and termination word bits
`define TM_PRELAUNCH 0
`define TM_3T 1
`define TM_IBT_150 2
`define TM_BAND 3

// drive strength word fields
`define DS_A_LSB 0
`define DS_B_LSB 2

`define WORD_RESET 4'h0

// b-side address bits driven inverted: 3..9, 11, 13..15
`define INV_ADDR_MASK 16'hebf8
`define INV_BANK_MASK 3'h7

`endif

// File: hdl/rcd_pkg.sv
// types shared by the driver configuration block
package rcd_pkg;

    typedef struct packed {
        logic [2:0] bank;
        logic [15:0] addr;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } ca_t;

    typedef struct packed {
        logic [1:0] cs_n;
        logic cke;
        logic odt;
    } ctl_t;

    typedef enum logic [1:0] {
        DRIVE_LIGHT = 2'b00,
        DRIVE_MODERATE = 2'b01,
        DRIVE_STRONG = 2'b10,
        DRIVE_RESERVED = 2'b11
    } drive_t;

endpackage : rcd_pkg

// File: verification/ctrl_model.sv
// behavioural memory controller driving the registered command bus
`timescale 1ns/100ps

module ctrl_model #(
    parameter int STAB_CYCLES = 8
) (
    output logic [1:0] cs_n,
    output logic cke,
    output logic odt,
    output rcd_pkg::ca_t ca
);
    // idle cycles still owed after a timing word write
    int stab_left = 0;

    initial begin
        cs_n = 2'h3;
        cke = 1'b0;
        odt = 1'b0;
        ca = '0;
    end

    task automatic access(input logic [3:0] word, input logic [3:0] data,
            input logic [10:0] upper, input logic ck, input logic od);
        cs_n <= 2'h0;
        ca <= {word[3], data[3:2], upper, data[1:0], word[2:0], 3'h7};
        cke <= ck;
        odt <= od;
        // any timing word write may move clock timing, so always wait it out
        if (word == 4'h2) stab_left = STAB_CYCLES;
    endtask : access

    task automatic command(input logic [1:0] sel, input rcd_pkg::ca_t c,
            input logic ck, input logic od);
        cs_n <= sel;
        ca <= c;
        cke <= ck;
        odt <= od;
    endtask : command

    // lines not in use flip so a held value cannot pass for a driven one
    task automatic idle(input logic ck, input logic od);
        cs_n <= 2'h3;
        ca <= ~ca;
        cke <= ck;
        odt <= od;
        if (stab_left > 0) stab_left = stab_left - 1;
    endtask : idle
endmodule : ctrl_model

// File: verification/driver_config_words_test.sv
// self-checking bench for configuration words zero to three
`timescale 1ns/100ps
`include "rcd_map.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module driver_config_words_test;
    typedef struct packed {
        rcd_pkg::ca_t a;
        rcd_pkg::ca_t b;
        rcd_pkg::ctl_t ca;
        rcd_pkg::ctl_t cb;
        logic [3:0] oe;
        logic [3:0] clk;
        logic [6:0] misc;
        logic [3:0] drv;
    } obs_t;
    typedef struct {
        int cyc;
        obs_t o;
    } note_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic run_clk = 1'b1;
    logic mirror = 1'b0;
    wire [1:0] cs_n;
    wire cke;
    wire odt;
    wire rcd_pkg::ca_t bus;
    wire obs_t seen;
    integer seed = 32'h3d33;
    int cyc = 0;
    int miscompares = 0;
    int comparisons = 0;
    note_t q[$];
    note_t n;
    logic [3:0] w [4];
    rcd_pkg::ca_t held_a;
    rcd_pkg::ca_t held_b;
    logic [1:0] da;
    logic [1:0] db;

    ctrl_model ctrl (.cs_n(cs_n), .cke(cke), .odt(odt), .ca(bus));
    driver_config_words dut (
        .ref_clk(ref_clk), .rst(rst), .chip_select_inputs(cs_n),
        .termination_control_inputs(odt), .clock_enable_inputs(cke),
        .addr_in(bus.addr), .bank_in(bus.bank), .ras_in_n(bus.ras_n),
        .cas_in_n(bus.cas_n), .we_in_n(bus.we_n), .mirror(mirror),
        .ca_out_a(seen.a), .ca_out_b(seen.b), .ca_oe_n_a(seen.oe[3]), .ca_oe_n_b(seen.oe[2]),
        .ctl_out_a(seen.ca), .ctl_out_b(seen.cb), .ctl_oe_n_a(seen.oe[1]),
        .ctl_oe_n_b(seen.oe[0]), .clock_pair_oe_n(seen.clk), .clock_loop_locked(seen.misc[6]),
        .prelaunch_early(seen.misc[5]), .timing_3t(seen.misc[4]),
        .freq_band_test(seen.misc[3]), .ibt_150(seen.misc[2]), .ibt_cmd_on(seen.misc[1]),
        .ibt_ctl_on(seen.misc[0]), .ca_drive_a(seen.drv[3:2]), .ca_drive_b(seen.drv[1:0])
    );

    always #5 if (run_clk) ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic clear_model;
        w = '{default: 4'h0};
        held_a = '0;
        held_b = '0;
        da = 2'h0;
        db = 2'h0;
    endtask : clear_model

    // kind 0 idle, 1 command, 2 configuration access
    task automatic step(input int kind);
        obs_t e;
        rcd_pkg::ca_t c;
        logic [1:0] sel;
        logic [3:0] wd;
        logic [3:0] dt;
        logic ck;
        logic od;
        logic mir;
        logic fl;
        c = 22'($random(seed));
        sel = 2'h1 << ($random(seed) & 1);
        {wd, dt, ck, od, mir} = 11'($random(seed));
        @(negedge ref_clk);
        if (ctrl.stab_left > 0) kind = 0;
        mirror <= mir;
        if (kind == 1) begin
            ctrl.command(sel, c, ck, od);
            held_a = c;
            held_b = w[0][0] ? c : c ^ {`INV_BANK_MASK, `INV_ADDR_MASK, 3'h0};
        end else if (kind == 2) begin
            ctrl.access(wd, dt, c.addr[10:0], ck, od);
            sel = 2'h0;
        end else begin
            ctrl.idle(ck, od);
            sel = 2'h3;
        end
        fl = (kind != 1) & w[0][1] & ~w[2][1];
        e.a = held_a;
        e.b = held_b;
        e.ca = {(sel == 2'h0) ? 2'h3 : sel, ck, od};
        e.cb = e.ca;
        e.oe = {w[0][2] | fl, w[0][3] | fl, w[0][2], w[0][3]};
        e.clk = w[1] | {w[0][2], w[0][3], w[0][2], w[0][3]};
        e.misc = {1'b1, w[2][0], w[2][1], w[2][3], w[2][2], ~mir, 1'b1};
        if (w[3][1:0] != 2'h3) da = w[3][1:0];
        if (w[3][3:2] != 2'h3) db = w[3][3:2];
        e.drv = {da, db};
        q.push_back('{cyc + 1, e});
        if (kind == 2 && wd < 4'h4) w[wd[1:0]] = dt;
    endtask : step

    // trailing idles let the last results land before anything else happens
    task automatic run(input int cnt, input string name);
        repeat (cnt) step({$random(seed)} % 3);
        step(0);
        step(0);
        $display("%s done", name);
    endtask : run

    always @(posedge ref_clk) begin
        #1;
        while (q.size() > 0 && q[0].cyc <= cyc) begin
            n = q.pop_front();
            `CHK("ca_a", n.o.a, seen.a)
            `CHK("ca_b", n.o.b, seen.b)
            `CHK("ctl", {n.o.ca, n.o.cb}, {seen.ca, seen.cb})
            `CHK("ca_oe", n.o.oe[3:2], seen.oe[3:2])
            `CHK("ctl_oe", n.o.oe[1:0], seen.oe[1:0])
            `CHK("clock_oe", n.o.clk, seen.clk)
            `CHK("timing", n.o.misc, seen.misc)
            `CHK("drive", n.o.drv, seen.drv)
        end
    end

    initial begin
        clear_model();
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk) rst <= 1'b0;
        run(400, "random traffic");
        @(negedge ref_clk) run_clk <= 1'b0;
        #203 run_clk <= 1'b1;
        run(200, "traffic after clock stop");
        @(negedge ref_clk) rst <= 1'b1;
        #1 `CHK("reset_clock_oe", 4'h0, seen.clk)
        `CHK("reset_drive", 4'h0, seen.drv)
        `CHK("reset_timing", 7'h03, seen.misc)
        `CHK("reset_oe", 4'h0, seen.oe)
        clear_model();
        repeat (2) @(negedge ref_clk);
        rst <= 1'b0;
        run(400, "traffic after reset");
        tally_and_finish();
    end

    // about 1,000 cycles of traffic plus the clock stop fit well inside this
    initial begin
        #50000;
        miscompares++;
        tally_and_finish();
    end
endmodule : driver_config_words_test
